// ===== hdl/mrfsk_coding_modulation.sv
// Functional notes
// - Two-bit PHY type: 0 off at reset, 1 FSK, 2 OFDM, 3 O-QPSK.
// - Transmit order: FEC, then interleave, then whitening, then symbol mapping.
// - FEC is terminated rate one-half convolutional code, constraint length four.
// - FEC scheme 0 non-recursive non-systematic, 1 recursive systematic.
// - Interleave when enabled for either scheme; always bypassed without FEC.
// - With defaults, sync-word select 1 turns FEC on.
// - Whitening enable 1 whitens transmit data.
// - Receive de-whitens payload when received header whitening bit is set.
// - With FEC, whitening acts on coded bits.
// - Raw framing mode never whitens.
// - 2-level: bit 0 gives -1, bit 1 gives +1.
// - 4-level pairs: 01 -1, 00 -1/3, 10 +1/3, 11 +1.
// - 4-level only for header and payload; rest 2-level.
// - Preamble invert negates preamble symbols on transmit only.
// - Full invert negates all transmit symbols, except preamble symbols when preamble invert is also set; receiver told to match.
// - Rate codes 0..5 mean 50,100,150,200,300,400 kHz.
// - Modulation index used both ways; index scaling on transmit only.
// - Data rate: 1x, 2x, 0.5x, 1x symbol rate by order and FEC.
// - Receiver senses two sync words, coded versus uncoded.
// - Symbols go to I/Q interface with power amplifier control.
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "mrfsk_codec_defines.svh"

module mrfsk_coding_modulation #(
    parameter int QW = 32
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic rxSfdHit,
    input wire logic rxSfdIndex,
    input wire logic rxHdrValid,
    input wire logic rxHdrWhiten,
    input wire logic rxBitValid,
    input wire logic rxBit,
    output mrfsk_codec_pkg::sym_t symbol,
    output logic symbolValid,
    output logic paEnable,
    output logic [1:0] phyTypeSelect,
    output logic [2:0] txModIndex,
    output logic [1:0] txModScale,
    output logic [1:0] txBt,
    output logic [2:0] rxModIndex,
    output logic rxInvert,
    output logic rxCoded,
    output logic rxOutBit,
    output logic rxOutValid
);
    import mrfsk_codec_pkg::*;

    localparam int CW = $clog2(QW + 1);

    if (QW < 32 || QW > 64) begin : g_bad_qw
        $error("QW must lie in 32..64");
    end

    typedef struct packed {
        logic [31:0] rdata;
        logic wrPend;
        logic [7:0] wrIdx;
        logic [1:0] pt;
        cfg_s cfg;
        cfg_s lc;
        logic lFec;
        logic lRaw;
        logic [15:0] sync0;
        logic [15:0] sync1;
        logic [7:0] feRate;
        phase_e phase;
        logic [8:0] tcnt;
        logic [QW-1:0] q;
        logic [CW-1:0] qCnt;
        logic [10:0] byteCnt;
        logic [10:0] len;
        logic [7:0] preLen;
        logic [7:0] dat;
        logic datFull;
        logic [2:0] enc;
        logic [8:0] lfsr;
        sym_t sym;
        logic symV;
        logic pa;
        logic rxCoded;
        logic rxWh;
        logic [8:0] rxLfsr;
        logic rxOut;
        logic rxOutV;
    } st_s;

    st_s s;
    st_s n;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic fecOf(input cfg_s c);
        return c.txSyncWordSelect ? c.coded1 : c.coded0;
    endfunction : fecOf

    function automatic logic rawOf(input cfg_s c);
        return c.txSyncWordSelect ? c.raw1 : c.raw0;
    endfunction : rawOf

    function automatic logic [8:0] rateCycles(input logic [2:0] code);
        case (code)
            3'h0: return `SYM_CYC_0;
            3'h1: return `SYM_CYC_1;
            3'h2: return `SYM_CYC_2;
            3'h3: return `SYM_CYC_3;
            3'h4: return `SYM_CYC_4;
            3'h5: return `SYM_CYC_5;
            default: return `SYM_CYC_0;
        endcase
    endfunction : rateCycles

    // Data rate in half symbol-rate units
    function automatic logic [2:0] rateHalves(input cfg_s c);
        logic [2:0] r;
        r = c.modulationOrder ? 3'h4 : 3'h2;
        return fecOf(c) ? (r >> 1) : r;
    endfunction : rateHalves

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic addrPhase;
        logic tick;
        logic body4;
        logic done;
        logic srcOk;
        logic inv;
        logic u;
        logic fb;
        logic [1:0] take;
        logic [1:0] c;
        logic [7:0] src;
        logic [15:0] cb;
        logic [15:0] cbi;
        logic [4:0] nb;
        logic [2:0] e;
        logic [8:0] w;
        logic [QW-1:0] qq;
        logic [QW-1:0] ext;
        logic [CW-1:0] qc;
        addrPhase = hsel & htrans[1] & hready;
        tick = 1'b0;
        body4 = 1'b0;
        done = 1'b0;
        srcOk = 1'b0;
        inv = 1'b0;
        u = 1'b0;
        fb = 1'b0;
        take = 2'h0;
        c = 2'h0;
        src = 8'h00;
        cb = 16'h0000;
        cbi = 16'h0000;
        nb = 5'h00;
        e = s.enc;
        w = s.lfsr;
        qq = s.q;
        ext = '0;
        qc = s.qCnt;
        n = s;
        n.symV = 1'b0;
        n.rxOutV = 1'b0;

        // ----------------------------------------
        // Bus slave: reads answered from address phase
        // ----------------------------------------
        n.wrPend = addrPhase & hwrite & (haddr[31:8] == 24'h000000);
        n.wrIdx = haddr[7:0];
        n.rdata = 32'h00000000;
        if (addrPhase && !hwrite && haddr[31:8] == 24'h000000) begin
            if (haddr[7:0] == `ADDR_PHY_CTRL) begin
                n.rdata = {30'h0, s.pt};
            end else if (haddr[7:0] == `ADDR_FSK_CFG) begin
                n.rdata = {11'h000, s.cfg};
            end else if (haddr[7:0] == `ADDR_SYNC) begin
                n.rdata = {s.sync1, s.sync0};
            end else if (haddr[7:0] == `ADDR_STATUS) begin
                n.rdata = {25'h0, rateHalves(s.cfg), s.rxCoded, s.pa, s.datFull,
                           s.phase != PH_IDLE};
            end else if (haddr[7:0] == `ADDR_FE_RATE) begin
                n.rdata = {24'h0, s.feRate};
            end
        end
        if (s.wrPend) begin
            if (s.wrIdx == `ADDR_PHY_CTRL) begin
                n.pt = hwdata[1:0];
            end else if (s.wrIdx == `ADDR_FSK_CFG) begin
                n.cfg = cfg_s'(hwdata[`FSK_CFG_W-1:0]);
            end else if (s.wrIdx == `ADDR_SYNC) begin
                n.sync0 = hwdata[15:0];
                n.sync1 = hwdata[31:16];
            end else if (s.wrIdx == `ADDR_FE_RATE) begin
                n.feRate = hwdata[7:0];
            end else if (s.wrIdx == `ADDR_TX_DATA && !s.datFull) begin
                n.dat = hwdata[7:0];
                n.datFull = 1'b1;
            end else if (s.wrIdx == `ADDR_TX_CMD && hwdata[`CMD_START_BIT]
                         && s.phase == PH_IDLE && s.pt == `PHY_FSK) begin
                n.lc = s.cfg;
                n.lFec = fecOf(s.cfg);
                n.lRaw = rawOf(s.cfg);
                n.len = hwdata[`CMD_LEN_MSB:0];
                n.preLen = hwdata[`CMD_PRE_MSB:`CMD_PRE_LSB];
                n.phase = PH_PRE;
                n.byteCnt = 11'h000;
                n.tcnt = rateCycles(s.cfg.symbolRateCode) - 9'h001;
                n.enc = 3'h0;
                n.lfsr = `PN9_SEED;
                n.q = '0;
                n.qCnt = '0;
                n.pa = 1'b1;
            end
        end

        // ----------------------------------------
        // Symbol pacing and mapping
        // ----------------------------------------
        if (s.phase != PH_IDLE) begin
            tick = s.tcnt == 9'h000;
            n.tcnt = tick ? rateCycles(s.lc.symbolRateCode) - 9'h001 : s.tcnt - 9'h001;
            body4 = s.lc.modulationOrder && (s.phase == PH_BODY || s.phase == PH_TAIL);
            if (tick && body4 && qc >= CW'(2)) begin
                take = 2'h2;
                c = {qq[QW-1], qq[QW-1] ? qq[QW-2] : ~qq[QW-2]};
            end else if (tick && !body4 && qc >= CW'(1)) begin
                take = 2'h1;
                c = {2{qq[QW-1]}};
            end
            if (take != 2'h0) begin
                inv = s.lc.symbolInvertAll ^ (s.phase == PH_PRE && s.lc.preambleInvert);
                n.sym = inv ? ~c : c;
                n.symV = 1'b1;
                qq = qq << take;
                qc = qc - CW'(take);
            end
        end

        // ----------------------------------------
        // Bit producer: one byte per step
        // ----------------------------------------
        case (s.phase)
            PH_PRE: begin
                done = s.byteCnt == {3'h0, s.preLen};
                src = `PRE_BYTE;
                srcOk = 1'b1;
            end
            PH_SYNC: begin
                done = s.byteCnt == `SYNC_BYTES;
                src = s.lc.txSyncWordSelect ? s.sync1[15:8] : s.sync0[15:8];
                if (s.byteCnt != 11'h000) begin
                    src = s.lc.txSyncWordSelect ? s.sync1[7:0] : s.sync0[7:0];
                end
                srcOk = 1'b1;
            end
            PH_BODY: begin
                done = s.byteCnt == s.len;
                src = s.dat;
                srcOk = s.datFull;
            end
            PH_TAIL: begin
                done = s.byteCnt == `TAIL_BYTES;
                srcOk = 1'b1;
            end
            PH_DRAIN: begin
                if (qc == '0 && tick) begin
                    n.phase = PH_IDLE;
                    n.pa = 1'b0;
                end
            end
            default: begin
                done = 1'b0;
            end
        endcase
        if (done) begin
            if (qc == '0) begin
                n.byteCnt = 11'h000;
                if (s.phase == PH_PRE) begin
                    n.phase = PH_SYNC;
                end else if (s.phase == PH_SYNC) begin
                    n.phase = PH_BODY;
                end else if (s.phase == PH_BODY && s.lFec) begin
                    n.phase = PH_TAIL;
                end else begin
                    n.phase = PH_DRAIN;
                end
            end
        end else if (srcOk && qc <= CW'(QW - 16)) begin
            if (s.lFec && (s.phase == PH_BODY || s.phase == PH_TAIL)) begin
                for (int i = 0; i < 8; i++) begin
                    u = src[7-i];
                    if (s.phase == PH_TAIL) begin
                        u = s.lc.fecSchemeSelect ? ^(e & `FEC_FB_TAPS) : 1'b0;
                    end
                    if (s.lc.fecSchemeSelect) begin
                        fb = u ^ (^(e & `FEC_FB_TAPS));
                        cb[15-2*i] = u;
                        cb[14-2*i] = ^({fb, e} & `FEC_POLY1);
                        e = {e[1:0], fb};
                    end else begin
                        cb[15-2*i] = ^({u, e} & `FEC_POLY0);
                        cb[14-2*i] = ^({u, e} & `FEC_POLY1);
                        e = {e[1:0], u};
                    end
                end
                n.enc = e;
                nb = 5'h10;
                if (s.lc.interleaveEnable) begin
                    for (int i = 0; i < 16; i++) begin
                        cbi[15-i] = cb[15-((i % 4) * 4 + i / 4)];
                    end
                    cb = cbi;
                end
            end else begin
                cb = {src, 8'h00};
                nb = 5'h08;
            end
            if ((s.phase == PH_BODY || s.phase == PH_TAIL)
                && s.lc.whiteningEnable && !s.lRaw) begin
                for (int i = 0; i < 16; i++) begin
                    if (5'(i) < nb) begin
                        cb[15-i] = cb[15-i] ^ w[0];
                        w = {w[0] ^ w[`PN9_TAP], w[8:1]};
                    end
                end
                n.lfsr = w;
            end
            ext = {cb, {(QW-16){1'b0}}};
            qq = qq | (ext >> qc);
            qc = qc + CW'(nb);
            n.byteCnt = s.byteCnt + 11'h001;
            if (s.phase == PH_BODY) begin
                n.datFull = 1'b0;
            end
        end
        n.q = qq;
        n.qCnt = qc;

        // ----------------------------------------
        // Receive side
        // ----------------------------------------
        if (rxSfdHit) begin
            n.rxCoded = rxSfdIndex ? s.cfg.coded1 : s.cfg.coded0;
        end
        if (rxHdrValid) begin
            n.rxWh = rxHdrWhiten;
            n.rxLfsr = `PN9_SEED;
        end else if (rxBitValid) begin
            n.rxOut = rxBit ^ (s.rxWh & s.rxLfsr[0]);
            n.rxOutV = 1'b1;
            if (s.rxWh) begin
                n.rxLfsr = {s.rxLfsr[0] ^ s.rxLfsr[`PN9_TAP], s.rxLfsr[8:1]};
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.pt <= `PHY_OFF;
            s.cfg <= cfg_s'(`FSK_CFG_RST);
            s.lc <= cfg_s'(`FSK_CFG_RST);
            s.phase <= PH_IDLE;
            s.lfsr <= `PN9_SEED;
            s.rxLfsr <= `PN9_SEED;
        end else begin
            s <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign symbol = s.sym;
    assign symbolValid = s.symV;
    assign paEnable = s.pa;
    assign phyTypeSelect = s.pt;
    assign txModIndex = s.lc.modulationIndex;
    assign txModScale = s.lc.modulationIndexScale;
    assign txBt = s.lc.bandwidthTimeSetting;
    assign rxModIndex = s.cfg.modulationIndex;
    assign rxInvert = s.cfg.symbolInvertAll;
    assign rxCoded = s.rxCoded;
    assign rxOutBit = s.rxOut;
    assign rxOutValid = s.rxOutV;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    phy_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (s.pt != `PHY_FSK && s.phase == PH_IDLE) |=> s.phase == PH_IDLE)
        else $error("packet started with FSK not selected");
    fec_latch_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(s.pa) |-> s.lFec == fecOf(s.lc))
        else $error("FEC enable not decoded from sync select");
    tail_fec_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s.phase == PH_TAIL |-> s.lFec)
        else $error("tail without FEC");
    raw_white_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (s.phase != PH_IDLE && s.lRaw) |=> $stable(s.lfsr))
        else $error("whitening ran in raw mode");
    two_level_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (s.symV && ($past(s.phase) == PH_PRE || $past(s.phase) == PH_SYNC))
        |-> (s.sym == 2'h0 || s.sym == 2'h3))
        else $error("4-level symbol outside header and payload");
    latch_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (s.phase != PH_IDLE && $past(s.phase) != PH_IDLE) |-> $stable(s.lc))
        else $error("settings changed inside a packet");
    pa_cover_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s.symV |-> s.pa ##1 (s.pa || s.phase == PH_IDLE))
        else $error("symbol sent with amplifier off");
    tick_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s.phase != PH_IDLE |-> s.tcnt < rateCycles(s.lc.symbolRateCode))
        else $error("symbol timer beyond rate period");
    rx_plain_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (rxBitValid && !rxHdrValid && !s.rxWh) |=> (s.rxOutV && s.rxOut == $past(rxBit)))
        else $error("bit changed without whitening");
    dual_sense_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rxSfdHit |=> s.rxCoded == ($past(rxSfdIndex) ? $past(s.cfg.coded1) : $past(s.cfg.coded0)))
        else $error("coded flag does not follow sync word");

endmodule : mrfsk_coding_modulation

// ===== shared/mrfsk_codec_defines.svh
`ifndef MRFSK_CODEC_DEFINES_SVH
`define MRFSK_CODEC_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_PHY_CTRL 8'h00
`define ADDR_FSK_CFG 8'h04
`define ADDR_SYNC 8'h08
`define ADDR_TX_CMD 8'h0c
`define ADDR_TX_DATA 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_FE_RATE 8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PHY_OFF 2'h0
`define PHY_FSK 2'h1
`define PHY_OFDM 2'h2
`define PHY_OQPSK 2'h3
`define FSK_CFG_W 21
`define FSK_CFG_RST 21'h040000
`define CMD_START_BIT 31
`define CMD_LEN_MSB 10
`define CMD_PRE_LSB 16
`define CMD_PRE_MSB 23
`define SYNC_BYTES 11'h002
`define TAIL_BYTES 11'h001
`define PRE_BYTE 8'h55

// ----------------------------------------
// Coding constants
// ----------------------------------------
`define FEC_POLY0 4'hf
`define FEC_POLY1 4'hb
`define FEC_FB_TAPS 3'h3
`define PN9_SEED 9'h1ff
`define PN9_TAP 4

// ----------------------------------------
// Symbol timing
// ----------------------------------------
`define CLK_KHZ 20000
`define SYM_CYC_0 9'(`CLK_KHZ / 50)
`define SYM_CYC_1 9'(`CLK_KHZ / 100)
`define SYM_CYC_2 9'(`CLK_KHZ / 150)
`define SYM_CYC_3 9'(`CLK_KHZ / 200)
`define SYM_CYC_4 9'(`CLK_KHZ / 300)
`define SYM_CYC_5 9'(`CLK_KHZ / 400)

`endif

// ===== shared/mrfsk_codec_pkg.sv
package mrfsk_codec_pkg;

    typedef enum logic [5:0] {
        PH_IDLE = 6'h01,
        PH_PRE = 6'h02,
        PH_SYNC = 6'h04,
        PH_BODY = 6'h08,
        PH_TAIL = 6'h10,
        PH_DRAIN = 6'h20
    } phase_e;

    // Symbol code: 00 = -1, 01 = -1/3, 10 = +1/3, 11 = +1
    typedef logic [1:0] sym_t;

    typedef struct packed {
        logic raw1;
        logic raw0;
        logic coded1;
        logic coded0;
        logic [1:0] bandwidthTimeSetting;
        logic [1:0] modulationIndexScale;
        logic [2:0] modulationIndex;
        logic [2:0] symbolRateCode;
        logic symbolInvertAll;
        logic preambleInvert;
        logic modulationOrder;
        logic whiteningEnable;
        logic txSyncWordSelect;
        logic interleaveEnable;
        logic fecSchemeSelect;
    } cfg_s;

endpackage : mrfsk_codec_pkg

// ===== test/iq_frontend_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Frontend and demodulator stand-in
// ----------------------------------------
module iq_frontend_model (
    input wire logic core_clk,
    input wire mrfsk_codec_pkg::sym_t symbol,
    input wire logic symbolValid,
    input wire logic paEnable,
    output logic rxSfdHit,
    output logic rxSfdIndex,
    output logic rxHdrValid,
    output logic rxHdrWhiten,
    output logic rxBitValid,
    output logic rxBit,
    output int strays
);
    import mrfsk_codec_pkg::*;

    initial begin
        rxSfdHit = 1'b0;
        rxSfdIndex = 1'b0;
        rxHdrValid = 1'b0;
        rxHdrWhiten = 1'b0;
        rxBitValid = 1'b0;
        rxBit = 1'b0;
        strays = 0;
    end

    // Symbols seen while the amplifier is off count as strays
    always @(posedge core_clk) begin
        if (symbolValid === 1'b1 && paEnable !== 1'b1) begin
            strays <= strays + 1;
        end
    end

    // Kind 0 sync word hit, 1 header, 2 payload bit
    task pulse(input logic [1:0] kind, input logic v);
        @(posedge core_clk);
        rxSfdHit <= (kind == 2'h0);
        rxSfdIndex <= v;
        rxHdrValid <= (kind == 2'h1);
        rxHdrWhiten <= v;
        rxBitValid <= (kind == 2'h2);
        rxBit <= v;
        @(posedge core_clk);
        rxSfdHit <= 1'b0;
        rxHdrValid <= 1'b0;
        rxBitValid <= 1'b0;
        // Released lines must not keep the last value
        rxSfdIndex <= ~v;
        rxHdrWhiten <= ~v;
        rxBit <= ~v;
    endtask : pulse
endmodule : iq_frontend_model

// ===== test/mrfsk_coding_modulation_test.sv
`timescale 1ns/1ps
`include "mrfsk_codec_defines.svh"
module mrfsk_coding_modulation_test;
    import mrfsk_codec_pkg::*;

    logic core_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] sync;
    logic [7:0] body;
    logic [8:0] pn;
    wire logic hreadyout, hresp, symbolValid, paEnable, rxInvert, rxCoded, rxOutBit, rxOutValid;
    wire logic rxSfdHit, rxSfdIndex, rxHdrValid, rxHdrWhiten, rxBitValid, rxBit;
    wire logic [31:0] hrdata;
    wire sym_t symbol;
    wire logic [1:0] phyTypeSelect, txModScale, txBt;
    wire logic [2:0] txModIndex, rxModIndex;
    int fails = 0, n_checks = 0, cycles = 0, gap = 0, seed, i, strays;
    bit inPkt = 1'b0;
    sym_t expQ[$];

    mrfsk_coding_modulation dut_u (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .rxSfdHit(rxSfdHit), .rxSfdIndex(rxSfdIndex), .rxHdrValid(rxHdrValid),
        .rxHdrWhiten(rxHdrWhiten), .rxBitValid(rxBitValid), .rxBit(rxBit), .symbol(symbol),
        .symbolValid(symbolValid), .paEnable(paEnable), .phyTypeSelect(phyTypeSelect),
        .txModIndex(txModIndex), .txModScale(txModScale), .txBt(txBt),
        .rxModIndex(rxModIndex), .rxInvert(rxInvert), .rxCoded(rxCoded),
        .rxOutBit(rxOutBit), .rxOutValid(rxOutValid));

    iq_frontend_model fe_u (.core_clk(core_clk), .symbol(symbol), .symbolValid(symbolValid),
        .paEnable(paEnable), .rxSfdHit(rxSfdHit), .rxSfdIndex(rxSfdIndex),
        .rxHdrValid(rxHdrValid), .rxHdrWhiten(rxHdrWhiten), .rxBitValid(rxBitValid),
        .rxBit(rxBit), .strays(strays));

    always #25 core_clk = ~core_clk;

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task final_report();
        $display("Checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task chk_sym(input sym_t got, input sym_t exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t symbol got %h exp %h", $time, got, exp);
        end
    endtask : chk_sym

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end

    // ----------------------------------------
    // Symbol monitor
    // ----------------------------------------
    always @(posedge core_clk) begin
        gap++;
        if (paEnable !== 1'b1) inPkt = 1'b0;
        if (symbolValid === 1'b1) begin
            if (inPkt) chk_word(gap, 50);
            inPkt = 1'b1;
            gap = 0;
            if (expQ.size() == 0) begin
                fails++;
                $display("ERROR %0t unexpected symbol", $time);
            end else begin
                chk_sym(symbol, expQ.pop_front());
            end
        end
    end

    // ----------------------------------------
    // Bus and packet tasks
    // ----------------------------------------
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk_word({31'h0, hresp}, 32'h0);
    endtask : ahb

    // One preamble byte, the sync word and one body byte, coded as cfg asks, with FEC modelled as scheme 0 without interleave
    task pkt(input logic [20:0] cfg);
        logic [55:0] all;
        logic [31:0] cw;
        logic [2:0] st;
        logic u;
        int nb;
        sym_t s;
        cw = {body, 24'h0};
        nb = 8;
        st = 3'h0;
        pn = `PN9_SEED;
        if (cfg[2] ? cfg[18] : cfg[17]) begin
            nb = 32;
            for (int k = 0; k < 16; k++) begin
                u = (k < 8) ? body[7-k] : 1'b0;
                cw[31-2*k] = ^({u, st} & `FEC_POLY0);
                cw[30-2*k] = ^({u, st} & `FEC_POLY1);
                st = {st[1:0], u};
            end
        end
        if (cfg[3] && !(cfg[2] ? cfg[20] : cfg[19])) begin
            for (int k = 31; k >= 32 - nb; k--) begin
                cw[k] = cw[k] ^ pn[0];
                pn = {pn[0] ^ pn[`PN9_TAP], pn[8:1]};
            end
        end
        all = {8'h55, sync, cw};
        for (int k = 55; k >= 32 - nb; k--) begin
            if (cfg[4] && k < 32) begin
                s = {all[k], ~(all[k] ^ all[k-1])};
                k--;
            end else begin
                s = all[k] ? 2'h3 : 2'h0;
            end
            if (cfg[6] || (cfg[5] && k >= 48)) begin
                s = ~s;
            end
            expQ.push_back(s);
        end
        ahb(1'b1, 8'h04, {11'h0, cfg});
        ahb(1'b1, 8'h10, {24'h0, body});
        ahb(1'b1, 8'h0c, 32'h80010001);
        do @(posedge core_clk); while (paEnable !== 1'b1);
        chk_word(txModIndex, cfg[12:10]);
        chk_word(txModScale, cfg[14:13]);
        chk_word(txBt, cfg[16:15]);
        do @(posedge core_clk); while (paEnable !== 1'b0);
        chk_word(expQ.size(), 0);
    endtask : pkt

    initial begin
        seed = 32'h8bcf;
        sync = 16'($random(seed));
        body = 8'($random(seed));
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        ahb(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'h0);
        ahb(1'b0, 8'h04, 32'h0);
        chk_word(rd, 32'h40000);
        ahb(1'b0, 8'h1c, 32'h0);
        chk_word(rd, 32'h0);
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, 8'h00, i);
            ahb(1'b0, 8'h00, 32'h0);
            chk_word(rd, i);
            chk_word({30'h0, phyTypeSelect}, i);
        end
        ahb(1'b1, 8'h00, 32'h1);
        // Index one and BT two keep 4-level legal
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, 8'h04, 32'h50400 | (i[0] << 2) | (i[1] << 4));
            ahb(1'b0, 8'h14, 32'h0);
            chk_word(rd[6:4], i[1] ? (i[0] ? 2 : 4) : (i[0] ? 1 : 2));
        end
        chk_word(rxModIndex, 32'h1);
        // Rate code 5: transmit divider 1 in the low nibble, receive divider 2 above
        ahb(1'b1, 8'h18, 32'h21);
        ahb(1'b0, 8'h18, 32'h0);
        chk_word(rd, 32'h21);
        ahb(1'b1, 8'h08, {sync, sync});
        pkt(21'h0502a2);
        pkt(21'h0546d0);
        chk_word(rxInvert, 32'h1);
        pkt(21'h05028c);
        pkt(21'h0d0288);
        fe_u.pulse(2'h0, 1'b1);
        @(negedge core_clk);
        chk_word(rxCoded, 32'h1);
        fe_u.pulse(2'h0, 1'b0);
        @(negedge core_clk);
        chk_word(rxCoded, 32'h0);
        // Plain header first, then a whitened one
        for (i = 0; i < 8; i++) begin
            if (i % 4 == 0) begin
                fe_u.pulse(2'h1, i[2]);
                pn = `PN9_SEED;
            end
            rd[0] = 1'($random(seed));
            fe_u.pulse(2'h2, rd[0]);
            @(negedge core_clk);
            chk_word({rxOutValid, rxOutBit}, {1'b1, rd[0] ^ (i[2] & pn[0])});
            pn = {pn[0] ^ pn[`PN9_TAP], pn[8:1]};
        end
        chk_word(strays, 0);
        final_report();
    end
endmodule : mrfsk_coding_modulation_test
